// [hdl/sdis_pkg.sv]
// Constants for the sync detect and interface select block
package sdis_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_OUTPUT_MODE = 8'h10;
	localparam logic [7:0] IDX_SYNC_STATUS = 8'h11;
	localparam logic [7:0] IDX_SELECT = 8'h12;
	localparam logic [9:0] ADDR_OUTPUT_MODE = {IDX_OUTPUT_MODE, 2'h0};
	localparam logic [9:0] ADDR_SYNC_STATUS = {IDX_SYNC_STATUS, 2'h0};
	localparam logic [9:0] ADDR_SELECT = {IDX_SELECT, 2'h0};

	// ------------------------------------------------------------
	// Output mode control fields
	// ------------------------------------------------------------
	localparam int BIT_PIXEL_DUAL = 6;
	localparam int BIT_DRIVE_HI = 5;
	localparam int BIT_DRIVE_LO = 4;
	localparam int BIT_OUTPUT_TRISTATE = 3;
	localparam int BIT_DETECT_POLARITY = 2;
	localparam logic [7:0] OUTPUT_MODE_MASK = 8'h7C;
	localparam logic [7:0] OUTPUT_MODE_RESET = 8'h30;

	// ------------------------------------------------------------
	// Sync activity and selection status fields
	// ------------------------------------------------------------
	localparam int BIT_HSYNC_DETECT = 7;
	localparam int BIT_GREEN_DETECT = 6;
	localparam int BIT_VSYNC_DETECT = 5;
	localparam int BIT_LINK_CLK_DETECT = 4;
	localparam int BIT_INTERFACE_CHOICE = 3;
	localparam int BIT_HSYNC_CHOICE = 2;
	localparam int BIT_VSYNC_CHOICE = 1;

	// ------------------------------------------------------------
	// Interface selection override fields
	// ------------------------------------------------------------
	localparam int BIT_INTERFACE_OVERRIDE = 7;
	localparam int BIT_INTERFACE_PREFERENCE = 6;
	localparam int BIT_HSYNC_OVERRIDE = 5;
	localparam int BIT_HSYNC_PREFERENCE = 4;
	localparam int BIT_VSYNC_OVERRIDE = 3;
	localparam int BIT_VSYNC_SELECT = 2;
	localparam logic [7:0] SELECT_MASK = 8'hFC;
	localparam logic [7:0] SELECT_RESET = 8'h00;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic IFACE_ANALOG = 1'b0;
	localparam logic IFACE_DIGITAL = 1'b1;
	localparam logic HSRC_HSYNC = 1'b0;
	localparam logic HSRC_GREEN = 1'b1;
	localparam logic VSRC_VSYNC = 1'b0;
	localparam logic VSRC_SEPARATOR = 1'b1;

	typedef enum logic [1:0] {
		SDIS_DRIVE_LOW,
		SDIS_DRIVE_MEDIUM,
		SDIS_DRIVE_HIGH
	} sdis_drive_t;

	// ------------------------------------------------------------
	// AXI responses
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int ACTIVITY_TIMEOUT_US = 100;
	localparam int ACTIVITY_TIMEOUT_CYC = ACTIVITY_TIMEOUT_US * CLK_MHZ;

endpackage

// [hdl/sdis_top.sv]
// Sync activity detectors, interface and sync source selection, output control
//
// Contract
// - Pixel select 0: one pixel per clock on even port; 1: both ports.
// - Drive field: upper bit 1 high, 01 medium, 00 low; reset 11.
// - Tristate bit 1 floats all outputs except sliced green and reference.
// - Sync detect pin is 1 on activity at polarity 0, 0 at polarity 1.
// - Hsync detect reads 1 while hsync toggles, 0 when held static.
// - Green sync detect reads 1 on activity on green input.
// - Vsync detect reads 1 while vsync toggles, 0 when held static.
// - Link clock detect reads 1 while the link clock toggles.
// - Analog detect is OR of three sync detects; digital is clock detect.
// - Auto choice: digital only gives 1, analog only 0, both preference.
// - Interface override forces choice to the preference bit.
// - Interface choice 0 is analog, 1 is digital.
// - Auto hsync: hsync only 0, green only 1, else preference.
// - Hsync override forces hsync choice to its preference bit.
// - Hsync choice 0 is dedicated hsync, 1 is green sync.
// - Auto vsync choice follows the vsync detect bit.
// - Vsync override forces vsync choice to the vsync select bit.
// - Interface override 0 automatic, 1 software; reset 0.
// - Interface preference 0 analog, 1 digital; reset 0.
// - Hsync preference 0 dedicated hsync, 1 green sync; reset 0.
// - Vsync source 0 is vsync input, 1 is sync separator.
`timescale 1ns/1ps

module sdis_top
	import sdis_pkg::*;
#(
	parameter int ACT_TIMEOUT = ACTIVITY_TIMEOUT_CYC,
	parameter int ADDR_W = 10
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Sync and link inputs
	input wire logic HSYNC_IN,
	input wire logic GREEN_SYNC_IN,
	input wire logic VSYNC_IN,
	input wire logic LINK_CLK_IN,
	// Selection results
	output logic INTERFACE_CHOICE,
	output logic HSYNC_SOURCE_CHOICE,
	output logic VSYNC_SOURCE_CHOICE,
	output logic SEEK_MODE,
	// Output control
	output logic SYNC_DETECT,
	output logic SYNC_DETECT_OE,
	output logic DATA_OE,
	output logic ODD_PORT_OE,
	output logic DUAL_PIXEL,
	output logic [1:0] DRIVE_STRENGTH,
	output logic SLICED_GREEN_SYNC_OUT_OE,
	output logic REFERENCE_OUT_OE
);

	localparam int CW = $clog2(ACT_TIMEOUT + 1);
	localparam logic [CW-1:0] TIMEOUT_LOAD = CW'(ACT_TIMEOUT);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
		word_index = 8'(addr >> 2);
	endfunction

	function automatic sdis_drive_t drive_decode(input logic [1:0] field);
		if (field[1]) begin
			drive_decode = SDIS_DRIVE_HIGH;
		end else if (field[0]) begin
			drive_decode = SDIS_DRIVE_MEDIUM;
		end else begin
			drive_decode = SDIS_DRIVE_LOW;
		end
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] output_mode_control;
	logic [7:0] interface_selection_override;
	logic [7:0] sync_activity_and_selection;

	// ------------------------------------------------------------
	// Input synchronisers and activity detectors
	// ------------------------------------------------------------
	logic [3:0] in_meta;
	logic [3:0] in_sync;
	logic [3:0] in_prev;
	logic [3:0] detect;
	logic [CW-1:0] quiet_cnt [4];

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			in_meta <= 4'h0;
			in_sync <= 4'h0;
			in_prev <= 4'h0;
		end else begin
			in_meta <= {LINK_CLK_IN, VSYNC_IN, GREEN_SYNC_IN, HSYNC_IN};
			in_sync <= in_meta;
			in_prev <= in_sync;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < 4; i++) begin
				quiet_cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (in_sync[i] != in_prev[i]) begin
					quiet_cnt[i] <= TIMEOUT_LOAD;
				end else if (quiet_cnt[i] != '0) begin
					quiet_cnt[i] <= quiet_cnt[i] - CW'(1);
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			detect[i] = (quiet_cnt[i] != '0);
		end
	end

	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	logic hs_det;
	logic green_det;
	logic vs_det;
	logic clk_det;
	logic analog_det;
	logic digital_det;
	logic next_interface;
	logic next_hsync;
	logic next_vsync;
	logic next_seek;

	assign hs_det = detect[0];
	assign green_det = detect[1];
	assign vs_det = detect[2];
	assign clk_det = detect[3];
	assign analog_det = hs_det | green_det | vs_det;
	assign digital_det = clk_det;

	always_comb begin
		next_seek = 1'b0;
		next_interface = INTERFACE_CHOICE;
		if (interface_selection_override[BIT_INTERFACE_OVERRIDE]) begin
			next_interface = interface_selection_override[BIT_INTERFACE_PREFERENCE];
		end else if (analog_det && digital_det) begin
			next_interface = interface_selection_override[BIT_INTERFACE_PREFERENCE];
		end else if (digital_det) begin
			next_interface = IFACE_DIGITAL;
		end else if (analog_det) begin
			next_interface = IFACE_ANALOG;
		end else begin
			next_seek = 1'b1;
		end
	end

	always_comb begin
		if (interface_selection_override[BIT_HSYNC_OVERRIDE]) begin
			next_hsync = interface_selection_override[BIT_HSYNC_PREFERENCE];
		end else if (hs_det && !green_det) begin
			next_hsync = HSRC_HSYNC;
		end else if (green_det && !hs_det) begin
			next_hsync = HSRC_GREEN;
		end else begin
			next_hsync = interface_selection_override[BIT_HSYNC_PREFERENCE];
		end
	end

	always_comb begin
		if (interface_selection_override[BIT_VSYNC_OVERRIDE]) begin
			next_vsync = interface_selection_override[BIT_VSYNC_SELECT];
		end else if (vs_det) begin
			next_vsync = VSRC_SEPARATOR;
		end else begin
			next_vsync = VSRC_VSYNC;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			INTERFACE_CHOICE <= IFACE_ANALOG;
			HSYNC_SOURCE_CHOICE <= HSRC_HSYNC;
			VSYNC_SOURCE_CHOICE <= VSRC_VSYNC;
			SEEK_MODE <= 1'b0;
		end else begin
			INTERFACE_CHOICE <= next_interface;
			HSYNC_SOURCE_CHOICE <= next_hsync;
			VSYNC_SOURCE_CHOICE <= next_vsync;
			SEEK_MODE <= next_seek;
		end
	end

	always_comb begin
		sync_activity_and_selection = 8'h00;
		sync_activity_and_selection[BIT_HSYNC_DETECT] = hs_det;
		sync_activity_and_selection[BIT_GREEN_DETECT] = green_det;
		sync_activity_and_selection[BIT_VSYNC_DETECT] = vs_det;
		sync_activity_and_selection[BIT_LINK_CLK_DETECT] = clk_det;
		sync_activity_and_selection[BIT_INTERFACE_CHOICE] = INTERFACE_CHOICE;
		sync_activity_and_selection[BIT_HSYNC_CHOICE] = HSYNC_SOURCE_CHOICE;
		sync_activity_and_selection[BIT_VSYNC_CHOICE] = VSYNC_SOURCE_CHOICE;
	end

	// ------------------------------------------------------------
	// Output control
	// ------------------------------------------------------------
	logic tristate;
	logic activity;

	assign tristate = output_mode_control[BIT_OUTPUT_TRISTATE];
	assign activity = analog_det | digital_det;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SYNC_DETECT <= 1'b0;
			SYNC_DETECT_OE <= 1'b0;
			DATA_OE <= 1'b0;
			ODD_PORT_OE <= 1'b0;
			DUAL_PIXEL <= 1'b0;
			DRIVE_STRENGTH <= SDIS_DRIVE_HIGH;
			SLICED_GREEN_SYNC_OUT_OE <= 1'b0;
			REFERENCE_OUT_OE <= 1'b0;
		end else begin
			SYNC_DETECT <= activity ^ output_mode_control[BIT_DETECT_POLARITY];
			SYNC_DETECT_OE <= !tristate;
			DATA_OE <= !tristate;
			DUAL_PIXEL <= output_mode_control[BIT_PIXEL_DUAL];
			ODD_PORT_OE <= !tristate && output_mode_control[BIT_PIXEL_DUAL];
			DRIVE_STRENGTH <= drive_decode(output_mode_control[BIT_DRIVE_HI:BIT_DRIVE_LO]);
			SLICED_GREEN_SYNC_OUT_OE <= 1'b1;
			REFERENCE_OUT_OE <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] wr_index;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic do_write;

	assign do_write = aw_held && w_held && !S_AXI_BVALID;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_held <= 1'b0;
			wr_index <= 8'h00;
			S_AXI_AWREADY <= 1'b0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held <= 1'b1;
			wr_index <= word_index(S_AXI_AWADDR);
			S_AXI_AWREADY <= 1'b0;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end else begin
			S_AXI_AWREADY <= !aw_held && !S_AXI_BVALID;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			w_held <= 1'b0;
			wr_byte <= 8'h00;
			wr_lane <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held <= 1'b1;
			wr_byte <= S_AXI_WDATA[7:0];
			wr_lane <= S_AXI_WSTRB[0];
			S_AXI_WREADY <= 1'b0;
		end else if (do_write) begin
			w_held <= 1'b0;
		end else begin
			S_AXI_WREADY <= !w_held && !S_AXI_BVALID;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			if (wr_index == IDX_OUTPUT_MODE || wr_index == IDX_SYNC_STATUS
					|| wr_index == IDX_SELECT) begin
				S_AXI_BRESP <= RESP_OKAY;
			end else begin
				S_AXI_BRESP <= RESP_SLVERR;
			end
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			output_mode_control <= OUTPUT_MODE_RESET;
		end else if (do_write && wr_lane && wr_index == IDX_OUTPUT_MODE) begin
			output_mode_control <= wr_byte & OUTPUT_MODE_MASK;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			interface_selection_override <= SELECT_RESET;
		end else if (do_write && wr_lane && wr_index == IDX_SELECT) begin
			interface_selection_override <= wr_byte & SELECT_MASK;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= RESP_OKAY;
			case (word_index(S_AXI_ARADDR))
				IDX_OUTPUT_MODE: begin
					S_AXI_RDATA <= {24'h000000, output_mode_control};
				end
				IDX_SYNC_STATUS: begin
					S_AXI_RDATA <= {24'h000000, sync_activity_and_selection};
				end
				IDX_SELECT: begin
					S_AXI_RDATA <= {24'h000000, interface_selection_override};
				end
				default: begin
					S_AXI_RDATA <= 32'h0000_0000;
					S_AXI_RRESP <= RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID;
		end
	end

endmodule

// [test/sdis_asserts.sv]
// Assertion checker for the sync detect and interface select block
`timescale 1ns/1ps
module sdis_asserts #(
	parameter int ACT_TIMEOUT = 20
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Read address and data
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	// Sync and link inputs
	input wire logic HSYNC_IN,
	input wire logic GREEN_SYNC_IN,
	input wire logic VSYNC_IN,
	input wire logic LINK_CLK_IN,
	// Selection results
	input wire logic INTERFACE_CHOICE,
	input wire logic SEEK_MODE,
	// Output control
	input wire logic SYNC_DETECT_OE,
	input wire logic DATA_OE,
	input wire logic ODD_PORT_OE,
	input wire logic DUAL_PIXEL,
	input wire logic [1:0] DRIVE_STRENGTH,
	input wire logic SLICED_GREEN_SYNC_OUT_OE,
	input wire logic REFERENCE_OUT_OE
);
	logic [3:0] pins;
	logic [3:0] pins_q;
	int quiet;

	assign pins = {HSYNC_IN, GREEN_SYNC_IN, VSYNC_IN, LINK_CLK_IN};

	// ------------------------------------------------------------
	// Cycles since the last pin change, saturating
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		pins_q <= pins;
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			quiet <= ACT_TIMEOUT;
		end else if (pins != pins_q) begin
			quiet <= 0;
		end else if (quiet < ACT_TIMEOUT) begin
			quiet <= quiet + 1;
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_odd_port_gate: assert property (ODD_PORT_OE == (DUAL_PIXEL && DATA_OE))
		else $error("odd port enable differs from pixel mode and three-state");
	a_float_together: assert property (DATA_OE == SYNC_DETECT_OE)
		else $error("data and sync detect enables differ");
	a_green_ref_stay: assert property ($past(RESET_N) |-> SLICED_GREEN_SYNC_OUT_OE && REFERENCE_OUT_OE)
		else $error("sliced green or reference output not driven");
	a_drive_legal: assert property (DRIVE_STRENGTH != 2'h3)
		else $error("drive strength code out of range");
	a_activity_ends_seek: assert property ($changed(pins) |-> ##[2:6] !SEEK_MODE)
		else $error("seek mode stays after sync activity");
	a_seek_after_quiet: assert property ($rose(SEEK_MODE) |-> quiet == ACT_TIMEOUT)
		else $error("seek mode entered before the quiet timeout");
	a_seek_holds_choice: assert property (SEEK_MODE && $past(SEEK_MODE) |-> $stable(INTERFACE_CHOICE))
		else $error("interface choice moved during seek mode");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer missing one cycle after address");

	c_seek_entry: cover property ($rose(SEEK_MODE));
	c_dual_port: cover property (ODD_PORT_OE);
	c_floated: cover property (!DATA_OE && REFERENCE_OUT_OE);
endmodule

// [test/sdis_video_src.sv]
// Video source model driving the sync inputs and the link clock
`timescale 1ns/1ps
module sdis_video_src #(
	parameter int HALF = 3
) (
	// Clock
	input wire logic clk,
	// Line enables: hsync, green, vsync, link clock
	input wire logic [3:0] en,
	// Driven lines
	output logic hsync,
	output logic green_sync,
	output logic vsync,
	output logic link_clk
);
	int cnt = 0;
	logic [3:0] lvl = 4'h0;

	// Enabled lines toggle, idle lines hold static
	always @(posedge clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			lvl <= lvl ^ en;
		end
	end

	assign {hsync, green_sync, vsync, link_clk} = lvl;
endmodule

// [test/testbench.sv]
// Self-checking testbench for the sync detect and interface select block
`timescale 1ns/1ps
module testbench;
	import sdis_pkg::*;
	logic CLK, RESET_N;
	logic [9:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
	logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, DRIVE_STRENGTH, rs;
	logic HSYNC_IN, GREEN_SYNC_IN, VSYNC_IN, LINK_CLK_IN, sk;
	logic INTERFACE_CHOICE, HSYNC_SOURCE_CHOICE, VSYNC_SOURCE_CHOICE, SEEK_MODE, SYNC_DETECT;
	logic SYNC_DETECT_OE, DATA_OE, ODD_PORT_OE, DUAL_PIXEL, SLICED_GREEN_SYNC_OUT_OE;
	logic REFERENCE_OUT_OE;
	logic [3:0] src_en, S_AXI_WSTRB;
	logic [7:0] st, m, sel_tab [4];
	int err_total, check_count, cyc;

	sdis_top #(.ACT_TIMEOUT(20)) u_dut (.CLK(CLK), .RESET_N(RESET_N),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .HSYNC_IN(HSYNC_IN),
		.GREEN_SYNC_IN(GREEN_SYNC_IN), .VSYNC_IN(VSYNC_IN), .LINK_CLK_IN(LINK_CLK_IN),
		.INTERFACE_CHOICE(INTERFACE_CHOICE), .HSYNC_SOURCE_CHOICE(HSYNC_SOURCE_CHOICE),
		.VSYNC_SOURCE_CHOICE(VSYNC_SOURCE_CHOICE), .SEEK_MODE(SEEK_MODE),
		.SYNC_DETECT(SYNC_DETECT), .SYNC_DETECT_OE(SYNC_DETECT_OE), .DATA_OE(DATA_OE),
		.ODD_PORT_OE(ODD_PORT_OE), .DUAL_PIXEL(DUAL_PIXEL), .DRIVE_STRENGTH(DRIVE_STRENGTH),
		.SLICED_GREEN_SYNC_OUT_OE(SLICED_GREEN_SYNC_OUT_OE), .REFERENCE_OUT_OE(REFERENCE_OUT_OE));

	sdis_video_src #(.HALF(3)) u_src (.clk(CLK), .en(src_en), .hsync(HSYNC_IN),
		.green_sync(GREEN_SYNC_IN), .vsync(VSYNC_IN), .link_clk(LINK_CLK_IN));

	// ------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------
	task automatic axw(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do begin
			@(posedge CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
		end while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
	endtask

	task automatic axr(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do begin
			@(posedge CLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
		end while (!S_AXI_RVALID);
		d = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'h0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Expected status byte from line activity and selection register
	function automatic logic [7:0] exp_stat(input logic [3:0] e, input logic [7:0] s);
		logic a, d, ic, hc, vc;
		a = |e[3:1];
		d = e[0];
		ic = s[7] ? s[6] : (d && !a) ? 1'h1 : (a && !d) ? 1'h0 : s[6];
		hc = s[5] ? s[4] : (e[3] ^ e[2]) ? e[2] : s[4];
		vc = s[3] ? s[2] : e[1];
		return {e, ic, hc, vc, 1'h0};
	endfunction

	initial begin
		CLK = 1'h0;
		forever #4 CLK = ~CLK;
	end

	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		RESET_N = 1'h0;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
		S_AXI_AWADDR = 10'h0;
		S_AXI_ARADDR = 10'h0;
		S_AXI_WDATA = 32'h0;
		S_AXI_WSTRB = 4'hF;
		src_en = 4'h0;
		sel_tab = '{8'h00, 8'h50, 8'hBC, 8'hE8};
		repeat (20) @(posedge CLK);
		RESET_N <= 1'h1;
		repeat (2) @(posedge CLK);
		axr(ADDR_OUTPUT_MODE, rd, rs);
		chk(rd, {24'h0, OUTPUT_MODE_RESET});
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		axr(ADDR_SELECT, rd, rs);
		chk(rd, 32'h0);
		axr(ADDR_SYNC_STATUS, rd, rs);
		chk(rd, 32'h0);
		chk({27'h0, DRIVE_STRENGTH, DATA_OE, ODD_PORT_OE, SEEK_MODE}, {27'h0, 2'(SDIS_DRIVE_HIGH), 3'h5});
		axw(10'h04C, 8'hFF, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		axr(10'h04C, rd, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		chk(rd, 32'h0);
		axw(ADDR_SYNC_STATUS, 8'hFF, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		axr(ADDR_SYNC_STATUS, rd, rs);
		chk(rd, 32'h0);
		S_AXI_WSTRB <= 4'h0;
		axw(ADDR_SELECT, 8'hFF, rs);
		S_AXI_WSTRB <= 4'hF;
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		axr(ADDR_SELECT, rd, rs);
		chk(rd, 32'h0);
		for (int k = 0; k < 4; k++) begin
			axw(ADDR_OUTPUT_MODE, {2'h1, 2'(k), 4'h0}, rs);
			repeat (3) @(posedge CLK);
			chk({27'h0, DRIVE_STRENGTH, DUAL_PIXEL, ODD_PORT_OE, DATA_OE}, {27'h0, k[1] ? 2'(SDIS_DRIVE_HIGH) : 2'(k), 3'h7});
		end
		axw(ADDR_OUTPUT_MODE, 8'hFF, rs);
		repeat (3) @(posedge CLK);
		chk({27'h0, DATA_OE, SYNC_DETECT_OE, ODD_PORT_OE, SLICED_GREEN_SYNC_OUT_OE, REFERENCE_OUT_OE}, 32'h3);
		axr(ADDR_OUTPUT_MODE, rd, rs);
		chk(rd, {24'h0, OUTPUT_MODE_MASK});
		axw(ADDR_OUTPUT_MODE, 8'h34, rs);
		repeat (3) @(posedge CLK);
		chk({30'h0, SYNC_DETECT, SYNC_DETECT_OE}, 32'h3);
		axw(ADDR_OUTPUT_MODE, OUTPUT_MODE_RESET, rs);
		foreach (sel_tab[i]) begin
			axw(ADDR_SELECT, sel_tab[i], rs);
			for (int e = 0; e < 16; e++) begin
				src_en <= 4'(e);
				repeat (40) @(posedge CLK);
				st = exp_stat(4'(e), sel_tab[i]);
				sk = (e == 0) && !sel_tab[i][7];
				m = sk ? 8'hF7 : 8'hFF;
				axr(ADDR_SYNC_STATUS, rd, rs);
				chk(rd & {24'h0, m}, {24'h0, st & m});
				chk({27'h0, INTERFACE_CHOICE & !sk, HSYNC_SOURCE_CHOICE, VSYNC_SOURCE_CHOICE, SEEK_MODE, SYNC_DETECT}, {27'h0, st[3] & !sk, st[2:1], sk, e != 0});
			end
		end
		src_en <= 4'h0;
		complete_run();
	end
endmodule

bind sdis_top sdis_asserts #(.ACT_TIMEOUT(ACT_TIMEOUT)) u_chk (.CLK(CLK), .RESET_N(RESET_N),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
	.HSYNC_IN(HSYNC_IN), .GREEN_SYNC_IN(GREEN_SYNC_IN), .VSYNC_IN(VSYNC_IN),
	.LINK_CLK_IN(LINK_CLK_IN), .INTERFACE_CHOICE(INTERFACE_CHOICE), .SEEK_MODE(SEEK_MODE),
	.SYNC_DETECT_OE(SYNC_DETECT_OE), .DATA_OE(DATA_OE), .ODD_PORT_OE(ODD_PORT_OE),
	.DUAL_PIXEL(DUAL_PIXEL), .DRIVE_STRENGTH(DRIVE_STRENGTH),
	.SLICED_GREEN_SYNC_OUT_OE(SLICED_GREEN_SYNC_OUT_OE), .REFERENCE_OUT_OE(REFERENCE_OUT_OE));
